// File: hw/link_tx_pkg.sv
package link_tx_pkg;

	localparam logic [11:0] ADDR_CTRL_ONE   = 12'h571;
	localparam logic [11:0] ADDR_CTRL_TWO   = 12'h572;
	localparam logic [11:0] ADDR_CTRL_THREE = 12'h573;
	localparam logic [11:0] ADDR_CTRL_FOUR  = 12'h574;
	localparam logic [11:0] ADDR_STATUS     = 12'h5A0;
	localparam logic [11:0] ADDR_CHECKSUM   = 12'h5A1;

	localparam logic [7:0] RST_CTRL_ONE   = 8'h14;
	localparam logic [7:0] RST_CTRL_TWO   = 8'h00;
	localparam logic [7:0] RST_CTRL_THREE = 8'h00;
	localparam logic [7:0] RST_CTRL_FOUR  = 8'h00;
	localparam logic [7:0] MASK_CTRL_ONE   = 8'hFF;
	localparam logic [7:0] MASK_CTRL_TWO   = 8'hF7;
	localparam logic [7:0] MASK_CTRL_THREE = 8'hFF;
	localparam logic [7:0] MASK_CTRL_FOUR  = 8'hF7;

	localparam int B1_STANDBY   = 7;
	localparam int B1_LANE_SYNC = 4;
	localparam int B1_ILAS_LO   = 2;
	localparam int B1_FRAME_ALIGN_CHAR_INSERT_OFF  = 1;
	localparam int B1_LINK_DOWN = 0;
	localparam int B2_SYNC_LO   = 6;
	localparam int B2_SYNC_INV  = 5;
	localparam int B2_SYNC_TYPE = 4;
	localparam int B2_BYPASS    = 2;
	localparam int B2_SYM_INV   = 1;
	localparam int B3_CSUM_LO   = 6;
	localparam int B3_INJ_LO    = 4;
	localparam int B3_PAT_LO    = 0;
	localparam int B4_DELAY_LO  = 4;

	localparam logic [1:0] ILAS_OFF    = 2'h0;
	localparam logic [1:0] ILAS_REPEAT = 2'h3;
	localparam logic [1:0] SYNC_FORCE_CGS  = 2'h2;
	localparam logic [1:0] SYNC_FORCE_DATA = 2'h3;
	localparam logic [1:0] CSUM_TABLE  = 2'h0;
	localparam logic [1:0] CSUM_FIELDS = 2'h1;
	localparam logic [1:0] INJ_SAMPLE  = 2'h0;
	localparam logic [1:0] INJ_ENCODER = 2'h1;
	localparam logic [1:0] INJ_SCRAM   = 2'h2;
	localparam logic [3:0] PAT_CHECKER = 4'h1;

	localparam logic [7:0] CHK_OCT_A = 8'hAA;
	localparam logic [7:0] CHK_OCT_B = 8'h55;
	localparam logic [9:0] CHK_SYM_A = 10'h2AA;
	localparam logic [9:0] CHK_SYM_B = 10'h155;

	localparam logic [7:0] K28_0 = 8'h1C;
	localparam logic [7:0] K28_3 = 8'h7C;
	localparam logic [7:0] K28_4 = 8'h9C;
	localparam logic [7:0] K28_5 = 8'hBC;
	localparam logic [7:0] K28_7 = 8'hFC;

	// two octets per frame, 32 frames per multiframe
	localparam logic [5:0] FRAME_MASK = 6'h01;
	localparam logic [5:0] MF_LAST    = 6'h3F;
	localparam logic [5:0] ILAS_Q_POS = 6'h01;
	localparam logic [5:0] CFG_FIRST  = 6'h02;
	localparam logic [5:0] CFG_END    = 6'h10;
	localparam logic [3:0] CFG_CSUM   = 4'hD;
	localparam logic [3:0] ILAS_CFG_MF  = 4'h1;
	localparam logic [3:0] ILAS_LAST_MF = 4'h3;

	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 16;

	localparam logic [7:0] CFG_TABLE [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h1F,
		8'h00, 8'h0D, 8'h2F, 8'h20, 8'h00, 8'h00, 8'h00};
	localparam int NUM_FIELDS = 21;
	localparam logic [3:0] FLD_OCTET [NUM_FIELDS] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3,
		4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8, 4'h9, 4'h9, 4'hA, 4'hA, 4'hB, 4'hC};
	localparam logic [2:0] FLD_LSB [NUM_FIELDS] = '{3'h0, 3'h0, 3'h4, 3'h0, 3'h5, 3'h6, 3'h0,
		3'h7, 3'h0, 3'h0, 3'h0, 3'h0, 3'h6, 3'h0, 3'h5, 3'h0, 3'h5, 3'h0, 3'h7, 3'h0, 3'h0};
	localparam logic [7:0] FLD_MASK [NUM_FIELDS] = '{8'hFF, 8'h0F, 8'h0F, 8'h1F, 8'h01, 8'h01,
		8'h1F, 8'h01, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h03, 8'h1F, 8'h07, 8'h1F, 8'h07, 8'h1F,
		8'h01, 8'hFF, 8'hFF};

	// 5b/6b and 3b/4b codes for negative running disparity, abcdei and fghj
	localparam logic [5:0] ENC6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19,
		6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13,
		6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E,
		6'h2B};
	localparam logic [3:0] ENC4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
	localparam logic [5:0] K28_6B = 6'h0F;
	localparam logic [3:0] ALT4   = 4'h7;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic       valid;
		logic [9:0] data;
	} tx_sym_t;

	typedef enum logic [1:0] {ST_CGS, ST_WAIT, ST_ILAS, ST_DATA} link_state_t;

endpackage

// File: hw/link_tx_control.sv
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,  // clock
	input  wire logic             reset_n,   // sync reset
	input  wire logic [WIDTH-1:0] in_data,   // write word
	input  wire logic             in_valid,  // write offered
	output logic                  in_ready,  // room left
	output logic      [WIDTH-1:0] out_data,  // head word
	output logic                  out_valid, // not empty
	input  wire logic             out_ready  // drain
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [CW-1:0] ONE_CNT  = CW'(1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [CW-1:0]    cnt_q;
	logic [CW-1:0]    cnt_d;
	logic             push;
	logic             pop;

	assign push     = in_valid & in_ready;
	assign pop      = out_valid & out_ready;
	assign out_data = mem_q[rd_ptr_q];
	assign cnt_d    = cnt_q + (push ? ONE_CNT : '0) - (pop ? ONE_CNT : '0);

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// flags registered from the next count so both ports come from flops
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			wr_ptr_q  <= '0;
			rd_ptr_q  <= '0;
			cnt_q     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wr_ptr_q  <= push ? AW'(wr_ptr_q + 1'b1) : wr_ptr_q;
			rd_ptr_q  <= pop ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;
			cnt_q     <= cnt_d;
			in_ready  <= cnt_d != FULL_CNT;
			out_valid <= cnt_d != '0;
		end
	end
endmodule

module link_tx_control (
	input  wire logic                  core_clk,                  // 200 MHz clock
	input  wire logic                  reset_n,                   // sync reset
	input  wire link_tx_pkg::reg_req_t reg_req,                   // register access
	output logic [7:0]                 reg_rdata,                 // read data
	input  wire logic                  sync_request_positive_pin, // sync pin +
	input  wire logic                  sync_request_negative_pin, // sync pin -
	input  wire logic [7:0]            in_data,                   // sample octet
	input  wire logic                  in_valid,                  // octet offered
	output logic                       in_ready,                  // fifo room
	output link_tx_pkg::tx_sym_t       tx_sym,                    // line symbol
	output logic                       link_active                // user data phase
);
	import link_tx_pkg::*;

	logic [7:0]  ctrl1_q;
	logic [7:0]  ctrl2_q;
	logic [7:0]  ctrl3_q;
	logic [7:0]  ctrl4_q;
	logic [1:0]  pin_s1_q;
	logic [1:0]  pin_s2_q;
	logic [1:0]  pin_s3_q;
	logic [1:0]  pin_q;
	logic        link_rst;
	logic        sync_raw;
	logic        sync_req;
	logic        sync_req_eff;
	logic [1:0]  sync_mode;
	logic [1:0]  ilas_mode;
	logic [1:0]  inj;
	logic [3:0]  pat;
	logic [3:0]  delay;
	link_state_t state_q;
	logic [3:0]  mf_cnt_q;
	logic [5:0]  oct_q;
	logic        frame_end;
	logic        mf_end;
	logic [7:0]  last_frame_q;
	logic [7:0]  csum;
	logic [7:0]  sample;
	logic        sample_k;
	logic [7:0]  oct_s;
	logic        k_s;
	logic        rd_q;
	logic [10:0] enc;
	logic [9:0]  sym;
	logic        chk_phase;
	logic        pat_on;
	logic [7:0]  fifo_data;
	logic        fifo_valid;
	logic        fifo_pop;

	assign link_rst  = !reset_n || ctrl1_q[B1_LINK_DOWN];
	assign sync_mode = ctrl2_q[B2_SYNC_LO +: 2];
	assign ilas_mode = ctrl1_q[B1_ILAS_LO +: 2];
	assign inj       = ctrl3_q[B3_INJ_LO +: 2];
	assign pat       = ctrl3_q[B3_PAT_LO +: 4];
	assign delay     = ctrl4_q[B4_DELAY_LO +: 4];
	assign pat_on    = pat == PAT_CHECKER;
	assign chk_phase = oct_q[0];

	// register port
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ctrl1_q <= RST_CTRL_ONE;
			ctrl2_q <= RST_CTRL_TWO;
			ctrl3_q <= RST_CTRL_THREE;
			ctrl4_q <= RST_CTRL_FOUR;
		end else if (reg_req.wr) begin
			case (reg_req.addr)
				ADDR_CTRL_ONE:   ctrl1_q <= reg_req.wdata & MASK_CTRL_ONE;
				ADDR_CTRL_TWO:   ctrl2_q <= reg_req.wdata & MASK_CTRL_TWO;
				ADDR_CTRL_THREE: ctrl3_q <= reg_req.wdata & MASK_CTRL_THREE;
				ADDR_CTRL_FOUR:  ctrl4_q <= reg_req.wdata & MASK_CTRL_FOUR;
				default: begin
				end
			endcase
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!reset_n || !reg_req.rd) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_req.addr)
				ADDR_CTRL_ONE:   reg_rdata <= ctrl1_q;
				ADDR_CTRL_TWO:   reg_rdata <= ctrl2_q;
				ADDR_CTRL_THREE: reg_rdata <= ctrl3_q;
				ADDR_CTRL_FOUR:  reg_rdata <= ctrl4_q;
				ADDR_STATUS:     reg_rdata <= {state_q, sync_req_eff, sync_req, 4'h0};
				ADDR_CHECKSUM:   reg_rdata <= csum;
				default:         reg_rdata <= 8'h00;
			endcase
		end
	end

	// three-stage pin capture; a level is taken once stages two and three agree
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pin_s1_q <= 2'h3;
			pin_s2_q <= 2'h3;
			pin_s3_q <= 2'h3;
			pin_q    <= 2'h3;
		end else begin
			pin_s1_q <= {sync_request_negative_pin, sync_request_positive_pin};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_q    <= (pin_q & (pin_s2_q ^ pin_s3_q)) | (pin_s3_q & ~(pin_s2_q ^ pin_s3_q));
		end
	end

	// sync is active low on the wire while B2_SYNC_INV is clear
	assign sync_raw = ctrl2_q[B2_SYNC_TYPE] ? pin_q[0] : (pin_q[0] & ~pin_q[1]);
	assign sync_req = ~(sync_raw ^ ctrl2_q[B2_SYNC_INV]);
	always_comb begin
		case (sync_mode)
			SYNC_FORCE_CGS:  sync_req_eff = 1'b1;
			SYNC_FORCE_DATA: sync_req_eff = 1'b0;
			default:         sync_req_eff = sync_req;
		endcase
	end

	// free-running multiframe octet counter
	always_ff @(posedge core_clk) begin
		if (link_rst) begin
			oct_q <= '0;
		end else begin
			oct_q <= oct_q + 6'h01;
		end
	end
	assign frame_end = (oct_q & FRAME_MASK) == FRAME_MASK;
	assign mf_end    = oct_q == MF_LAST;

	always_ff @(posedge core_clk) begin
		if (link_rst) begin
			state_q  <= ST_CGS;
			mf_cnt_q <= '0;
		end else if (sync_req_eff) begin
			state_q  <= ST_CGS;
			mf_cnt_q <= '0;
		end else begin
			case (state_q)
				ST_CGS: begin
					state_q  <= ST_WAIT;
					mf_cnt_q <= '0;
				end
				ST_WAIT: begin
					if (mf_end && (ilas_mode == ILAS_OFF || mf_cnt_q == delay)) begin
						state_q  <= (ilas_mode == ILAS_OFF) ? ST_DATA : ST_ILAS;
						mf_cnt_q <= '0;
					end else if (mf_end) begin
						mf_cnt_q <= mf_cnt_q + 4'h1;
					end
				end
				ST_ILAS: begin
					if (mf_end && mf_cnt_q == ILAS_LAST_MF) begin
						state_q  <= (ilas_mode == ILAS_REPEAT) ? ST_ILAS : ST_DATA;
						mf_cnt_q <= '0;
					end else if (mf_end) begin
						mf_cnt_q <= mf_cnt_q + 4'h1;
					end
				end
				ST_DATA: begin
				end
				default: state_q <= ST_CGS;
			endcase
		end
	end

	function automatic logic [7:0] checksum(input logic [1:0] mode);
		logic [7:0] s;
		s = 8'h00;
		if (mode == CSUM_TABLE) begin
			for (int i = 0; i < 13; i++) begin
				s = s + CFG_TABLE[i];
			end
		end else if (mode == CSUM_FIELDS) begin
			for (int i = 0; i < NUM_FIELDS; i++) begin
				s = s + ((CFG_TABLE[FLD_OCTET[i]] >> FLD_LSB[i]) & FLD_MASK[i]);
			end
		end
		return s;
	endfunction
	assign csum = checksum(ctrl3_q[B3_CSUM_LO +: 2]);

	assign fifo_pop = state_q == ST_DATA && !link_rst;

	sample_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.in_data   (in_data),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	// an empty fifo in the data phase sends 8'h00, or K28_5 when B1_STANDBY is set
	always_comb begin
		sample   = 8'h00;
		sample_k = 1'b0;
		if (fifo_valid) begin
			sample = fifo_data;
		end else if (ctrl1_q[B1_STANDBY]) begin
			sample   = K28_5;
			sample_k = 1'b1;
		end
		if (inj == INJ_SAMPLE && pat_on) begin
			sample   = chk_phase ? CHK_OCT_B : CHK_OCT_A;
			sample_k = 1'b0;
		end
	end

	always_comb begin
		oct_s = K28_5;
		k_s   = 1'b1;
		case (state_q)
			ST_ILAS: begin
				if (oct_q == '0) begin
					oct_s = K28_0;
				end else if (mf_end) begin
					oct_s = K28_3;
				end else if (mf_cnt_q == ILAS_CFG_MF && oct_q == ILAS_Q_POS) begin
					oct_s = K28_4;
				end else if (mf_cnt_q == ILAS_CFG_MF && oct_q >= CFG_FIRST && oct_q < CFG_END) begin
					k_s   = 1'b0;
					oct_s = (4'(oct_q - CFG_FIRST) == CFG_CSUM) ? csum :
						CFG_TABLE[4'(oct_q - CFG_FIRST)];
				end else begin
					k_s   = 1'b0;
					oct_s = {2'h0, oct_q};
				end
			end
			ST_DATA: begin
				oct_s = sample;
				k_s   = sample_k;
				// repeated frame tail becomes an alignment character
				if (!ctrl1_q[B1_FRAME_ALIGN_CHAR_INSERT_OFF] && !sample_k && frame_end && sample == last_frame_q) begin
					oct_s = (mf_end && ctrl1_q[B1_LANE_SYNC]) ? K28_3 : K28_7;
					k_s   = 1'b1;
				end
				if (inj == INJ_SCRAM && pat_on) begin
					oct_s = chk_phase ? CHK_OCT_B : CHK_OCT_A;
					k_s   = 1'b0;
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (link_rst) begin
			last_frame_q <= 8'h00;
		end else if (state_q == ST_DATA && frame_end) begin
			last_frame_q <= sample;
		end
	end

	function automatic logic [10:0] encode(input logic [7:0] d, input logic k, input logic rd);
		logic [5:0] c6;
		logic [3:0] c4;
		logic       rd1;
		logic       alt;
		c6 = k ? K28_6B : ENC6[d[4:0]];
		rd1 = rd ^ ($countones(c6) != 3);
		if (rd && (($countones(c6) != 3) || (!k && d[4:0] == 5'h07))) begin
			c6 = ~c6;
		end
		alt = d[7:5] == 3'h7 && (k || (!rd1 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 ||
			d[4:0] == 5'h14)) || (rd1 && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E)));
		c4 = alt ? ALT4 : ENC4[d[7:5]];
		if (rd1 && (($countones(c4) != 2) || d[7:5] == 3'h3)) begin
			c4 = ~c4;
		end
		// balanced k28 tails take the other form after a negative six-bit block
		if (k && !rd1 && ($countones(c4) == 2) && d[7:5] != 3'h3) begin
			c4 = ~c4;
		end
		return {rd1 ^ ($countones(c4) != 2), c6, c4};
	endfunction
	assign enc = encode(oct_s, k_s, rd_q);

	always_comb begin
		sym = ctrl2_q[B2_BYPASS] ? {2'h0, oct_s} : enc[9:0];
		if (inj == INJ_ENCODER && pat_on) begin
			sym = chk_phase ? CHK_SYM_B : CHK_SYM_A;
		end
		if (ctrl2_q[B2_SYM_INV]) begin
			sym = ~sym;
		end
	end

	// powered-down link sends nothing
	always_ff @(posedge core_clk) begin
		if (link_rst) begin
			rd_q        <= 1'b0;
			tx_sym      <= '0;
			link_active <= 1'b0;
		end else begin
			rd_q        <= ctrl2_q[B2_BYPASS] ? rd_q : enc[10];
			tx_sym      <= '{valid: 1'b1, data: sym};
			link_active <= state_q == ST_DATA;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence ilas_last_mf;
		state_q == ST_ILAS && mf_end && mf_cnt_q == ILAS_LAST_MF;
	endsequence
	sequence powered_down;
		ctrl1_q[B1_LINK_DOWN] [*2];
	endsequence

	ilas_repeat_a: assert property (ilas_last_mf and ilas_mode == ILAS_REPEAT && !sync_req_eff
		&& !link_rst
		|=> state_q == ST_ILAS && mf_cnt_q == '0) else $error("ilas did not repeat");
	frame_align_char_insert_off_a: assert property (ctrl1_q[B1_FRAME_ALIGN_CHAR_INSERT_OFF] && state_q == ST_DATA
		|-> !(k_s && oct_s == K28_7)) else $error("alignment char while disabled");
	cgs_follow_a: assert property (sync_req_eff && !ctrl1_q[B1_LINK_DOWN]
		|=> state_q == ST_CGS ##1 (tx_sym.data == ($past(ctrl2_q[B2_SYM_INV]) ?
		~$past(enc[9:0]) : $past(enc[9:0])) || $past(ctrl2_q[B2_BYPASS]) || $past(pat_on)
		|| $past(ctrl1_q[B1_LINK_DOWN]))) else $error("no cgs");
	link_down_a: assert property (powered_down |-> !tx_sym.valid && !link_active
		&& state_q == ST_CGS) else $error("link active while down");
	sync_force_a: assert property ((sync_mode == SYNC_FORCE_CGS |-> sync_req_eff) and
		(sync_mode == SYNC_FORCE_DATA |-> !sync_req_eff)) else $error("sync force");
	sync_pin_a: assert property (sync_mode == 2'h0 && ctrl2_q[B2_SYNC_TYPE]
		|-> sync_req_eff == (pin_q[0] == ctrl2_q[B2_SYNC_INV])) else $error("sync pin");
	bypass_sym_a: assert property (ctrl2_q[B2_BYPASS] && !ctrl2_q[B2_SYM_INV] && !pat_on
		&& !ctrl1_q[B1_LINK_DOWN] |=> tx_sym.data == {2'h0, $past(oct_s)})
		else $error("bypass symbol");
	sym_inv_a: assert property (ctrl2_q[B2_SYM_INV] && !ctrl2_q[B2_BYPASS] && !pat_on
		&& !ctrl1_q[B1_LINK_DOWN] |=> tx_sym.data == ~$past(enc[9:0]))
		else $error("symbol not inverted");
	csum_zero_a: assert property (ctrl3_q[B3_CSUM_LO +: 2] == 2'h2 |-> csum == 8'h00)
		else $error("checksum not zero");
	ilas_delay_a: assert property (state_q == ST_WAIT && mf_end && mf_cnt_q == delay
		&& ilas_mode != ILAS_OFF && !sync_req_eff && !link_rst
		|=> state_q == ST_ILAS ##1 oct_q == 6'h01)
		else $error("ilas start boundary");
endmodule

// File: test/sync_receiver_model.sv
`timescale 1ns/1ps
module sync_receiver_model #(
	parameter int K_NEEDED = 4
) (
	input  wire logic                 core_clk,  // clock
	input  wire logic                 reset_n,   // sync reset
	input  wire link_tx_pkg::tx_sym_t tx_sym,    // line symbol seen
	input  wire logic                 neg_fault, // drive minus pin wrongly
	output logic                      sync_p,    // sync pin +
	output logic                      sync_n     // sync pin -
);
	import link_tx_pkg::*;
	int k_cnt_q;

	// counting restarts whenever the link goes quiet, so a link reset re-requests
	always_ff @(posedge core_clk) begin
		if (!reset_n || tx_sym.valid !== 1'b1) begin
			k_cnt_q <= 0;
		end else if (k_cnt_q < K_NEEDED && (tx_sym.data === 10'h0FA || tx_sym.data === 10'h305)) begin
			k_cnt_q <= k_cnt_q + 1;
		end
	end

	assign sync_p = (k_cnt_q >= K_NEEDED);
	// fault case drives the minus pin equal to the plus pin, which a pair receiver cannot read as released
	assign sync_n = neg_fault ? sync_p : ~sync_p;
endmodule

// File: test/test_serial_link_transmit_control.sv
`timescale 1ns/1ps
module test_serial_link_transmit_control;
	import link_tx_pkg::*;
	logic       core_clk;
	logic       reset_n;
	reg_req_t   reg_req;
	logic [7:0] reg_rdata;
	logic       sync_p;
	logic       sync_n;
	logic       neg_fault;
	logic [7:0] in_data;
	logic       in_valid;
	logic       in_ready;
	tx_sym_t    tx_sym;
	logic       link_active;
	int         errors;
	int         n_tests;
	int         cycles;
	int         seed;
	int         n;
	logic [7:0] rd_exp [$];
	logic [7:0] rd_mask [$];
	logic [9:0] sym_q [$];
	logic [9:0] skip_a;
	logic [9:0] skip_b;
	logic [9:0] d0;
	logic [9:0] d1;
	logic [7:0] oct;
	logic [7:0] sum_t;
	logic [7:0] sum_f;
	logic       rd_seen;

	link_tx_control link_tx_control_inst (.core_clk(core_clk), .reset_n(reset_n),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .sync_request_positive_pin(sync_p),
		.sync_request_negative_pin(sync_n), .in_data(in_data), .in_valid(in_valid),
		.in_ready(in_ready), .tx_sym(tx_sym), .link_active(link_active));
	sync_receiver_model sync_receiver_model_inst (.core_clk(core_clk), .reset_n(reset_n),
		.tx_sym(tx_sym), .neg_fault(neg_fault), .sync_p(sync_p), .sync_n(sync_n));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task complete_run;
		if (errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk);
		reg_req.wr <= 1'b0;
		@(posedge core_clk);
	endtask

	task rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
		rd_exp.push_back(e);
		rd_mask.push_back(m);
		reg_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk);
		reg_req.rd <= 1'b0;
		@(posedge core_clk);
	endtask

	task wait_act(input int lim);
		n = 0;
		while (link_active !== 1'b1 && n < lim) begin
			@(posedge core_clk);
			n++;
		end
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge core_clk) begin
		if (rd_seen) check(10'(reg_rdata & rd_mask.pop_front()), 10'(rd_exp.pop_front()));
		rd_seen <= reg_req.rd;
		if (sym_q.size() > 0 && tx_sym.valid === 1'b1 && tx_sym.data !== skip_a
			&& tx_sym.data !== skip_b) check(tx_sym.data, sym_q.pop_front());
		cycles++;
		if (cycles == 20000) begin
			errors++;
			complete_run();
		end
	end

	initial begin
		reset_n = 1'b0;
		reg_req = '0;
		in_data = 8'h00;
		in_valid = 1'b0;
		neg_fault = 1'b0;
		rd_seen = 1'b0;
		skip_a = 10'h000;
		skip_b = 10'h000;
		errors = 0;
		n_tests = 0;
		cycles = 0;
		seed = 52;
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		rd(ADDR_CTRL_ONE, RST_CTRL_ONE, 8'hFF);
		rd(ADDR_CTRL_TWO, RST_CTRL_TWO, 8'hFF);
		rd(ADDR_CTRL_THREE, RST_CTRL_THREE, 8'hFF);
		rd(ADDR_CTRL_FOUR, RST_CTRL_FOUR, 8'hFF);
		rd(12'h575, 8'h00, 8'hFF);
		wr(ADDR_CTRL_TWO, 8'hFF);
		rd(ADDR_CTRL_TWO, 8'hF7, 8'hFF);
		wr(ADDR_CTRL_TWO, 8'h00);
		// released sync walks the link into user data
		wait_act(1000);
		check(10'(link_active), 10'h001);
		rd(ADDR_STATUS, 8'hC0, 8'hFF);
		wr(ADDR_CTRL_TWO, 8'h20);
		repeat (8) @(posedge core_clk);
		rd(ADDR_STATUS, 8'h30, 8'hFF);
		#1 check(10'(tx_sym.data === 10'h0FA || tx_sym.data === 10'h305), 10'h001);
		wr(ADDR_CTRL_TWO, 8'h00);
		neg_fault <= 1'b1;
		repeat (8) @(posedge core_clk);
		rd(ADDR_STATUS, 8'h30, 8'h30);
		wr(ADDR_CTRL_TWO, 8'h10);
		repeat (8) @(posedge core_clk);
		rd(ADDR_STATUS, 8'h00, 8'h30);
		neg_fault <= 1'b0;
		wr(ADDR_CTRL_TWO, 8'h00);
		// link down keeps registers but silences the line
		wr(ADDR_CTRL_ONE, 8'h1D);
		repeat (3) @(posedge core_clk);
		#1 check(10'(tx_sym.valid), 10'h000);
		check(10'(link_active), 10'h000);
		rd(ADDR_CTRL_ONE, 8'h1D, 8'hFF);
		wr(ADDR_CTRL_ONE, 8'h1C);
		n = 0;
		repeat (800) begin
			@(posedge core_clk);
			if (link_active !== 1'b0) n++;
		end
		check(10'(n), 10'h000);
		rd(ADDR_STATUS, 8'h80, 8'hC0);
		wr(ADDR_CTRL_FOUR, 8'hF0);
		wr(ADDR_CTRL_ONE, 8'h15);
		wr(ADDR_CTRL_ONE, 8'h14);
		wait_act(2000);
		// sixteenth boundary after release, then four multiframes of alignment
		check(10'(n >= 1200 && n <= 1340), 10'h001);
		wr(ADDR_CTRL_FOUR, 8'h00);
		wr(ADDR_CTRL_ONE, 8'h91);
		wr(ADDR_CTRL_ONE, 8'h90);
		wait_act(300);
		check(10'(link_active), 10'h001);
		repeat (3) @(posedge core_clk);
		#1 check(10'(tx_sym.data === 10'h0FA || tx_sym.data === 10'h305), 10'h001);
		sum_t = 8'h00;
		sum_f = 8'h00;
		for (int i = 0; i < 13; i++) sum_t += CFG_TABLE[i];
		for (int i = 0; i < NUM_FIELDS; i++) sum_f += (CFG_TABLE[FLD_OCTET[i]] >> FLD_LSB[i]) & FLD_MASK[i];
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTRL_THREE, 8'(i << 6));
			repeat (4) @(posedge core_clk);
			rd(ADDR_CHECKSUM, (i == 0) ? sum_t : (i == 1) ? sum_f : 8'h00, 8'hFF);
		end
		wr(ADDR_CTRL_THREE, 8'h00);
		// fill the buffer while held in sync, then force data and drain in order
		for (int inv = 0; inv < 2; inv++) begin
			wr(ADDR_CTRL_ONE, 8'h12);
			wr(ADDR_CTRL_TWO, 8'h84 | 8'(inv << 1));
			skip_a = {10{inv[0]}};
			skip_b = 10'h0BC ^ {10{inv[0]}};
			n = 0;
			oct = (8'($random(seed)) & 8'h7F) | 8'h01;
			in_data <= oct;
			in_valid <= 1'b1;
			while (n < 40) begin
				@(posedge core_clk);
				if (in_ready !== 1'b1) break;
				sym_q.push_back({2'b00, oct} ^ {10{inv[0]}});
				n++;
				oct = (8'($random(seed)) & 8'h7F) | 8'h01;
				in_data <= oct;
			end
			in_valid <= 1'b0;
			check(10'(n), 10'(FIFO_DEPTH));
			wr(ADDR_CTRL_TWO, 8'hC4 | 8'(inv << 1));
			n = 0;
			while (sym_q.size() > 0 && n < 400) begin
				@(posedge core_clk);
				n++;
			end
			check(10'(sym_q.size()), 10'h000);
		end
		wr(ADDR_CTRL_TWO, 8'hC4);
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_CTRL_THREE, 8'(i << 4) | 8'h01);
			repeat (4) @(posedge core_clk);
			#1 d0 = tx_sym.data;
			@(posedge core_clk);
			#1 d1 = tx_sym.data;
			check(d0 ^ d1, (i == 1) ? 10'h3FF : 10'h0FF);
		end
		complete_run();
	end
endmodule
